// ===== inc/fwf_defs.vh
// Constants for the deleted-data write and track format command block
`ifndef FWF_DEFS_VH
`define FWF_DEFS_VH
`define FWF_OP_WRDEL     6'h09
`define FWF_OP_FMT       6'h0d
`define FWF_MT_BIT       7
`define FWF_DD_BIT       6
`define FWF_HEAD_BIT     2
`define FWF_WR_NBYTES    4'd9
`define FWF_FMT_NBYTES   4'd6
`define FWF_MARK_ID      8'hfe
`define FWF_MARK_DATA    8'hfb
`define FWF_MARK_DEL     8'hf8
`define FWF_GAP_BYTE     8'h4e
`define FWF_SYNC_BYTE    8'h00
`define FWF_PAD_BYTE     8'h00
`define FWF_SYNC_LAST    15'd11
`define FWF_GAP2_LAST    15'd21
`define FWF_CRC_INIT     16'hffff
`define FWF_CRC_POLY     16'h1021
`define FWF_ST0_INVALID  8'h80
`define FWF_IC_NORMAL    2'b00
`define FWF_IC_ABNORMAL  2'b01
`define FWF_RES_FULL     3'd7
`define FWF_RES_ONE      3'd1
`define FWF_FIFO_WIDTH   8
`define FWF_FIFO_DEPTH   32
`define FWF_FIFO_AW      5
`define FWF_F_SYNC0      4'd0
`define FWF_F_IDMARK     4'd1
`define FWF_F_ID         4'd2
`define FWF_F_IDCRC      4'd3
`define FWF_F_GAP2       4'd4
`define FWF_F_SYNC1      4'd5
`define FWF_F_DMARK      4'd6
`define FWF_F_DATA       4'd7
`define FWF_F_DCRC       4'd8
`define FWF_F_GAP3       4'd9
`define FWF_F_GAP4       4'd10
`endif

// ===== rtl/fwf_core.v
// Deleted-data sector write and track format command engine
//
// Notes on behaviour
// - Deleted write equals normal write but records the deleted data mark
// - Deleted write opcode 001001 with multi-track and density; select byte
// - Execution moves host bytes to the drive one after another
// - Deleted write returns three status bytes then cylinder head sector size
// - Format opcode 001101, bit 7 zero, density bit; select byte
// - Format starts at an index pulse and writes every field of each sector
// - Format fills each data field with the filler byte
// - Supplied sector numbers are written unchecked, any order allowed
// - Format runs until the next index pulse or terminal count
// - Format returns three status bytes and four meaningless ID bytes
// - CRC of each data field is written right after that field
// - Sector number increments after each written sector, multi-sector
// - Terminal count or underrun mid-field pads a write data field with zeros
`include "fwf_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module fwf_core (
    input  wire       clk,
    input  wire       nrst,
    input  wire       ce,
    input  wire       host_valid,
    input  wire [7:0] host_data,
    output wire       host_ready,
    output reg        res_valid,
    output reg  [7:0] res_data,
    input  wire       res_ack,
    output reg        dreq,
    output reg        busy,
    input  wire       index_n,
    input  wire       tc,
    output reg        disk_valid,
    output reg  [7:0] disk_data,
    output reg        disk_mark,
    input  wire       disk_ready,
    output reg        write_gate,
    output reg        double_density_flag,
    output reg        head_select,
    output reg        drive_select_hi,
    output reg        drive_select_lo
);
    localparam S_IDLE  = 6'b000001;
    localparam S_CMD   = 6'b000010;
    localparam S_INDEX = 6'b000100;
    localparam S_FIELD = 6'b001000;
    localparam S_FIN   = 6'b010000;
    localparam S_RES   = 6'b100000;

    reg  [5:0]  st_q;
    reg  [3:0]  fld_q;
    reg  [14:0] cnt_q;
    reg  [3:0]  nb_q;
    reg  [7:0]  cmd_q;
    reg  [7:0]  prm_q [1:8];
    reg         is_wr_q;
    reg         inv_q;
    reg  [7:0]  cyl_q;
    reg  [7:0]  hid_q;
    reg  [7:0]  sec_q;
    reg  [7:0]  size_q;
    reg  [7:0]  done_q;
    reg  [15:0] crc_q;
    reg         pad_q;
    reg         under_q;
    reg         eoc_q;
    reg         tc_q;
    reg         idx_seen_q;
    reg  [7:0]  res_q [0:6];
    reg  [2:0]  ri_q;
    reg  [2:0]  nres_q;
    reg  [2:0]  idx_s_q;
    reg  [1:0]  tc_s_q;
    wire        f_valid;
    wire [7:0]  f_data;
    wire        f_ready;
    wire        adv;
    wire        need_host;
    wire        idx_pulse;
    wire [14:0] dlen;
    wire [7:0]  dbyte;
    wire [7:0]  gap3;

    function [15:0] crc_byte;
        input [15:0] c;
        input [7:0]  b;
        integer i;
        reg [15:0] r;
        begin
            r = c ^ {b, 8'h00};
            for (i = 0; i < 8; i = i + 1) begin
                r = r[15] ? ({r[14:0], 1'b0} ^ `FWF_CRC_POLY)
                          : {r[14:0], 1'b0};
            end
            crc_byte = r;
        end
    endfunction

    fwf_fifo #(
        .WIDTH (`FWF_FIFO_WIDTH),
        .DEPTH (`FWF_FIFO_DEPTH),
        .AW    (`FWF_FIFO_AW)
    ) u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .ce        (ce),
        .in_valid  (host_valid),
        .in_data   (host_data),
        .in_ready  (host_ready),
        .out_valid (f_valid),
        .out_data  (f_data),
        .out_ready (f_ready)
    );

    // Index edge is taken from the second and third stages only
    assign idx_pulse = ~idx_s_q[1] & idx_s_q[2];
    assign adv       = (st_q == S_FIELD) & (~disk_valid | disk_ready);
    assign need_host = (fld_q == `FWF_F_ID) |
                       ((fld_q == `FWF_F_DATA) & is_wr_q & ~pad_q & ~tc_q);
    assign f_ready   = (st_q == S_IDLE) | (st_q == S_CMD) | (adv & need_host);
    // Format sizes its data field from the size parameter, never from the
    // data length byte left behind by an earlier write command
    assign dlen      = !is_wr_q ? (15'h0080 << prm_q[2][2:0]) :
                       (size_q == 8'h00) ? {7'h00, prm_q[8]}
                                         : (15'h0080 << size_q[2:0]);
    assign gap3      = is_wr_q ? prm_q[7] : prm_q[4];
    assign dbyte     = !is_wr_q ? prm_q[5] :
                       (need_host & f_valid) ? f_data : `FWF_PAD_BYTE;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            idx_s_q <= 3'h7;
            tc_s_q  <= 2'h0;
        end else if (ce) begin
            idx_s_q <= {idx_s_q[1:0], index_n};
            tc_s_q  <= {tc_s_q[0], tc};
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= S_IDLE;
            fld_q <= `FWF_F_SYNC0;
            cnt_q <= 15'h0000;
            nb_q <= 4'h0;
            cmd_q <= 8'h00;
            is_wr_q <= 1'b0;
            inv_q <= 1'b0;
            cyl_q <= 8'h00;
            hid_q <= 8'h00;
            sec_q <= 8'h00;
            size_q <= 8'h00;
            done_q <= 8'h00;
            crc_q <= `FWF_CRC_INIT;
            pad_q <= 1'b0;
            under_q <= 1'b0;
            eoc_q <= 1'b0;
            tc_q <= 1'b0;
            idx_seen_q <= 1'b0;
            ri_q <= 3'h0;
            nres_q <= 3'h0;
            res_valid <= 1'b0;
            res_data <= 8'h00;
            dreq <= 1'b0;
            busy <= 1'b0;
            disk_valid <= 1'b0;
            disk_data <= 8'h00;
            disk_mark <= 1'b0;
            write_gate <= 1'b0;
            double_density_flag <= 1'b0;
            head_select <= 1'b0;
            drive_select_hi <= 1'b0;
            drive_select_lo <= 1'b0;
        end else if (ce) begin
            busy       <= (st_q != S_IDLE);
            write_gate <= (st_q == S_FIELD);
            dreq       <= (st_q == S_FIELD) & need_host;
            if (tc_s_q[1] && (st_q == S_FIELD || st_q == S_INDEX)) begin
                tc_q <= 1'b1;
            end
            if (idx_pulse && st_q == S_FIELD) begin
                idx_seen_q <= 1'b1;
            end
            case (st_q)
                S_IDLE: begin
                    if (f_valid) begin
                        cmd_q   <= f_data;
                        nb_q    <= 4'h1;
                        tc_q    <= 1'b0;
                        pad_q   <= 1'b0;
                        under_q <= 1'b0;
                        eoc_q   <= 1'b0;
                        inv_q   <= 1'b0;
                        idx_seen_q <= 1'b0;
                        if (f_data[5:0] == `FWF_OP_WRDEL) begin
                            is_wr_q <= 1'b1;
                            st_q    <= S_CMD;
                        end else if (f_data[5:0] == `FWF_OP_FMT &&
                                     !f_data[`FWF_MT_BIT]) begin
                            is_wr_q <= 1'b0;
                            st_q    <= S_CMD;
                        end else begin
                            inv_q <= 1'b1;
                            st_q  <= S_FIN;
                        end
                    end
                end
                S_CMD: begin
                    if (f_valid) begin
                        prm_q[nb_q] <= f_data;
                        nb_q <= nb_q + 4'h1;
                        if (nb_q == (is_wr_q ? `FWF_WR_NBYTES
                                             : `FWF_FMT_NBYTES) - 4'h1) begin
                            st_q <= S_INDEX;
                        end
                    end
                end
                S_INDEX: begin
                    head_select     <= prm_q[1][`FWF_HEAD_BIT];
                    drive_select_hi <= prm_q[1][1];
                    drive_select_lo <= prm_q[1][0];
                    double_density_flag <= cmd_q[`FWF_DD_BIT];
                    cnt_q  <= 15'h0000;
                    done_q <= 8'h00;
                    if (is_wr_q) begin
                        cyl_q  <= prm_q[2];
                        hid_q  <= prm_q[3];
                        sec_q  <= prm_q[4];
                        size_q <= prm_q[5];
                        fld_q  <= `FWF_F_SYNC1;
                        st_q   <= S_FIELD;
                    end else if (idx_pulse) begin
                        size_q <= prm_q[2];
                        fld_q  <= `FWF_F_SYNC0;
                        st_q   <= S_FIELD;
                    end else if (tc_q) begin
                        st_q <= S_FIN;
                    end
                end
                S_FIELD: begin
                    if (adv) begin
                        disk_valid <= 1'b1;
                        disk_mark  <= 1'b0;
                        cnt_q      <= cnt_q + 15'h0001;
                        case (fld_q)
                            `FWF_F_SYNC0, `FWF_F_SYNC1: begin
                                disk_data <= `FWF_SYNC_BYTE;
                                if (cnt_q == `FWF_SYNC_LAST) begin
                                    cnt_q <= 15'h0000;
                                    fld_q <= (fld_q == `FWF_F_SYNC0)
                                             ? `FWF_F_IDMARK : `FWF_F_DMARK;
                                end
                            end
                            `FWF_F_IDMARK: begin
                                disk_data <= `FWF_MARK_ID;
                                disk_mark <= 1'b1;
                                crc_q <= crc_byte(`FWF_CRC_INIT, `FWF_MARK_ID);
                                cnt_q <= 15'h0000;
                                fld_q <= `FWF_F_ID;
                            end
                            `FWF_F_ID: begin
                                if (f_valid) begin
                                    disk_data <= f_data;
                                    crc_q <= crc_byte(crc_q, f_data);
                                    case (cnt_q[1:0])
                                        2'h0: cyl_q <= f_data;
                                        2'h1: hid_q <= f_data;
                                        2'h2: sec_q <= f_data;
                                        default: size_q <= f_data;
                                    endcase
                                    if (cnt_q == 15'h0003) begin
                                        cnt_q <= 15'h0000;
                                        fld_q <= `FWF_F_IDCRC;
                                    end
                                end else begin
                                    disk_valid <= 1'b0;
                                    cnt_q <= cnt_q;
                                end
                            end
                            `FWF_F_IDCRC, `FWF_F_DCRC: begin
                                disk_data <= cnt_q[0] ? crc_q[7:0]
                                                      : crc_q[15:8];
                                if (cnt_q[0]) begin
                                    cnt_q <= 15'h0000;
                                    fld_q <= (fld_q == `FWF_F_IDCRC)
                                             ? `FWF_F_GAP2 : `FWF_F_GAP3;
                                end
                            end
                            `FWF_F_GAP2: begin
                                disk_data <= `FWF_GAP_BYTE;
                                if (cnt_q == `FWF_GAP2_LAST) begin
                                    cnt_q <= 15'h0000;
                                    fld_q <= `FWF_F_SYNC1;
                                end
                            end
                            `FWF_F_DMARK: begin
                                disk_data <= is_wr_q ? `FWF_MARK_DEL
                                                     : `FWF_MARK_DATA;
                                disk_mark <= 1'b1;
                                crc_q <= crc_byte(`FWF_CRC_INIT, is_wr_q
                                        ? `FWF_MARK_DEL : `FWF_MARK_DATA);
                                cnt_q <= 15'h0000;
                                fld_q <= `FWF_F_DATA;
                            end
                            `FWF_F_DATA: begin
                                disk_data <= dbyte;
                                crc_q <= crc_byte(crc_q, dbyte);
                                if (is_wr_q && (tc_q || !f_valid)) begin
                                    pad_q <= 1'b1;
                                end
                                if (need_host && !f_valid) begin
                                    under_q <= 1'b1;
                                end
                                if (cnt_q == dlen - 15'h0001) begin
                                    cnt_q <= 15'h0000;
                                    fld_q <= `FWF_F_DCRC;
                                end
                            end
                            `FWF_F_GAP3: begin
                                disk_data <= `FWF_GAP_BYTE;
                                if (cnt_q[7:0] + 8'h01 >= gap3) begin
                                    cnt_q <= 15'h0000;
                                    pad_q <= 1'b0;
                                    done_q <= done_q + 8'h01;
                                    if (is_wr_q) begin
                                        sec_q <= sec_q + 8'h01;
                                        fld_q <= `FWF_F_SYNC1;
                                        if (tc_q || under_q) begin
                                            st_q <= S_FIN;
                                        end else if (sec_q == prm_q[6]) begin
                                            if (cmd_q[`FWF_MT_BIT] &&
                                                !head_select) begin
                                                head_select <= 1'b1;
                                                hid_q <= 8'h01;
                                                sec_q <= 8'h01;
                                            end else begin
                                                eoc_q <= 1'b1;
                                                st_q  <= S_FIN;
                                            end
                                        end
                                    end else if (tc_q || idx_seen_q) begin
                                        st_q <= S_FIN;
                                    end else begin
                                        fld_q <= (done_q + 8'h01 >= prm_q[3])
                                                 ? `FWF_F_GAP4
                                                 : `FWF_F_SYNC0;
                                    end
                                end
                            end
                            default: begin
                                disk_data <= `FWF_GAP_BYTE;
                                if (tc_q || idx_seen_q) begin
                                    st_q <= S_FIN;
                                end
                            end
                        endcase
                    end
                end
                S_FIN: begin
                    // Last drive byte must be taken before results start
                    if (!disk_valid || disk_ready) begin
                        disk_valid <= 1'b0;
                        disk_mark  <= 1'b0;
                        ri_q       <= 3'h0;
                        res_valid  <= 1'b1;
                        res_q[0] <= inv_q ? `FWF_ST0_INVALID
                            : {((under_q | eoc_q) ? `FWF_IC_ABNORMAL
                                                  : `FWF_IC_NORMAL),
                               3'h0, head_select, drive_select_hi,
                               drive_select_lo};
                        res_data <= inv_q ? `FWF_ST0_INVALID
                            : {((under_q | eoc_q) ? `FWF_IC_ABNORMAL
                                                  : `FWF_IC_NORMAL),
                               3'h0, head_select, drive_select_hi,
                               drive_select_lo};
                        res_q[1] <= {eoc_q, 2'h0, under_q, 4'h0};
                        res_q[2] <= 8'h00;
                        res_q[3] <= cyl_q;
                        res_q[4] <= hid_q;
                        res_q[5] <= sec_q;
                        res_q[6] <= size_q;
                        nres_q <= inv_q ? `FWF_RES_ONE : `FWF_RES_FULL;
                        st_q <= S_RES;
                    end
                end
                S_RES: begin
                    if (res_ack) begin
                        ri_q <= ri_q + 3'h1;
                        if (ri_q + 3'h1 == nres_q) begin
                            res_valid <= 1'b0;
                            st_q <= S_IDLE;
                        end else begin
                            res_data <= res_q[ri_q + 3'h1];
                        end
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule // fwf_core
`default_nettype wire

// ===== rtl/fwf_fifo.v
// Byte FIFO between the host data port and the command engine
`timescale 1ns/10ps
`default_nettype none
module fwf_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    input  wire             clk,
    input  wire             nrst,
    input  wire             ce,
    input  wire             in_valid,
    input  wire [WIDTH-1:0] in_data,
    output wire             in_ready,
    output wire             out_valid,
    output wire [WIDTH-1:0] out_data,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wp_q;
    reg [AW-1:0]    rp_q;
    reg [AW:0]      cnt_q;
    reg             full_q;
    reg             empty_q;
    wire            push;
    wire            pop;

    assign in_ready  = ~full_q;
    assign out_valid = ~empty_q;
    assign out_data  = mem_q[rp_q];
    assign push      = ce & in_valid & ~full_q;
    assign pop       = ce & out_ready & ~empty_q;

    always @(posedge clk) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp_q    <= {AW{1'b0}};
            rp_q    <= {AW{1'b0}};
            cnt_q   <= {(AW+1){1'b0}};
            full_q  <= 1'b0;
            empty_q <= 1'b1;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q   <= cnt_q + 1'b1;
                empty_q <= 1'b0;
                full_q  <= (cnt_q == DEPTH - 1);
            end else if (pop && !push) begin
                cnt_q   <= cnt_q - 1'b1;
                full_q  <= 1'b0;
                empty_q <= (cnt_q == 1);
            end
        end
    end
endmodule // fwf_fifo
`default_nettype wire

// ===== verif/fwf_core_checker.sv
// Port assertions for the command engine
`timescale 1ns/10ps
`default_nettype none
module fwf_core_checker (
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic       res_valid,
    input wire logic       res_ack,
    input wire logic [7:0] res_data,
    input wire logic       disk_valid,
    input wire logic       disk_ready,
    input wire logic [7:0] disk_data,
    input wire logic       disk_mark,
    input wire logic       write_gate,
    input wire logic       head_select,
    input wire logic       drive_select_hi,
    input wire logic       drive_select_lo
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [3:0] acks_q;
    wire  [2:0] sel = {head_select, drive_select_hi, drive_select_lo};
    always @(posedge clk or negedge nrst)
        if (!nrst) acks_q <= 4'h0;
        else acks_q <= !res_valid ? 4'h0 : acks_q + {3'h0, res_ack};
    AST_DISK_HOLD: assert property (disk_valid && !disk_ready |=>
        disk_valid && $stable(disk_data)) else $error("stalled byte moved");
    AST_RES_HOLD: assert property (res_valid && !res_ack |=>
        res_valid && $stable(res_data)) else $error("result byte moved");
    AST_RES_CNT: assert property (acks_q <= 4'h7)
        else $error("more than seven result bytes");
    AST_RES_END: assert property (res_valid && res_ack && acks_q == 4'h6
        |=> !res_valid) else $error("result phase too long");
    AST_RES_STAY: assert property (res_valid && res_ack && acks_q < 4'h6
        |=> res_valid) else $error("result phase too short");
    AST_MARK: assert property (disk_valid && disk_mark |->
        disk_data inside {8'hfe, 8'hfb, 8'hf8}) else $error("bad mark");
    AST_SEL: assert property (write_gate && $past(write_gate) |->
        $stable(sel)) else $error("select changed while writing");
    AST_RES_QUIET: assert property (res_valid |-> !disk_valid)
        else $error("disk write during result phase");
    cover property (disk_valid && disk_ready && disk_mark && disk_data == 8'hf8);
    cover property (disk_valid && disk_ready && disk_mark && disk_data == 8'hfe);
    cover property (res_valid && res_ack && acks_q == 4'h6);
endmodule // fwf_core_checker
bind fwf_core fwf_core_checker fwf_core_checker_inst (.*);
`default_nettype wire

// ===== verif/fwf_drive_model.sv
// Drive stand-in: takes bytes with stalls, makes index pulses
`timescale 1ns/10ps
`default_nettype none
module fwf_drive_model (
    input  wire logic clk,
    input  wire logic index_req,
    output logic      disk_ready,
    output logic      index_n
);
    logic [1:0] ph_q  = 2'h0;
    logic [3:0] idx_q = 4'h0;
    // Refuses one byte in four so the engine must hold
    assign disk_ready = ph_q != 2'h3;
    // Pulled-up index pin, low for eight cycles per pulse
    assign index_n = idx_q == 4'h0;
    always @(posedge clk) begin
        ph_q  <= ph_q + 2'h1;
        idx_q <= index_req ? 4'h8 : idx_q - {3'h0, idx_q != 4'h0};
    end
endmodule // fwf_drive_model
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the command engine
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 0, nrst = 0, host_valid = 0, res_ack = 0, index_req = 0;
    logic [7:0] host_data = 8'h00, d, fm[10];
    logic [7:0] wr[9] = '{8'h49, 8'h05, 8'h03, 8'h01, 8'h02, 8'h00, 8'h03,
                          8'h01, 8'h04};
    logic [15:0] lf = 16'd52131, ak = 16'd52131, cv;
    logic [8:0] e, exp_disk[$], exp_res[$];
    wire host_ready, res_valid, dreq, busy, index_n, disk_valid, disk_mark;
    wire disk_ready, write_gate, dd, hs, dsh, dsl;
    wire [7:0] res_data, disk_data;
    int num_errors = 0, checked = 0;
    fwf_core fwf_core_inst (.clk(clk), .nrst(nrst), .ce(1'b1), .tc(1'b0),
        .host_valid(host_valid), .host_data(host_data), .dreq(dreq),
        .host_ready(host_ready), .res_valid(res_valid), .busy(busy),
        .res_data(res_data), .res_ack(res_ack), .index_n(index_n),
        .disk_valid(disk_valid), .disk_data(disk_data), .disk_mark(disk_mark),
        .disk_ready(disk_ready), .write_gate(write_gate), .head_select(hs),
        .double_density_flag(dd), .drive_select_hi(dsh), .drive_select_lo(dsl));
    fwf_drive_model fwf_drive_model_inst (.clk(clk), .index_req(index_req),
        .disk_ready(disk_ready), .index_n(index_n));
    initial forever #5 clk = ~clk;
    function automatic [15:0] nx(input [15:0] v);
        nx = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(string n, logic [7:0] s, logic [7:0] x);
        checked++;
        if (s !== x) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic send(logic [7:0] b);
        host_data = b;
        host_valid = 1;
        while (!host_ready) @(posedge clk) #1;
        @(posedge clk) #1;
    endtask
    // Notes n expected drive bytes, folding them into the running CRC when c is set
    task automatic put(int n, logic [8:0] b, bit c);
        repeat (n) begin
            exp_disk.push_back(b);
            if (c) for (int i = 7; i >= 0; i--)
                cv = {cv[14:0], 1'b0} ^ ((cv[15] ^ b[i]) ? 16'h1021 : 16'h0);
        end
    endtask
    task automatic crcs();
        put(1, {1'b0, cv[15:8]}, 0);
        put(1, {1'b0, cv[7:0]}, 0);
    endtask
    task automatic drain();
        for (int i = 0; i < 5000 && exp_disk.size() + exp_res.size(); i++)
            @(posedge clk);
        #1 chk("pending", 8'(exp_disk.size() + exp_res.size()), 8'h00);
    endtask
    task automatic pulse();
        index_req = 1;
        @(posedge clk) #1;
        index_req = 0;
    endtask
    task automatic summarize();
        $display("Checks %0d, errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        if (disk_valid && disk_ready) begin
            e = exp_disk.size() ? exp_disk.pop_front() : 9'h04e;
            chk("disk_data", disk_data, e[7:0]);
            chk("disk_mark", disk_mark, e[8]);
        end
        if (res_valid && res_ack) begin
            e = exp_res.size() ? exp_res.pop_front() : 9'h0ff;
            if (!e[8]) chk("res_data", res_data, e[7:0]);
        end
        #1 ak = nx(ak);
        res_ack = res_valid & ak[0];
    end
    initial begin
        #400000 num_errors++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clk);
        #1 nrst = 1;
        chk("host_ready", host_ready, 8'h01);
        // deleted write of two sectors, then end sector stop
        for (int s = 0; s < 2; s++) begin
            put(12, 9'h000, 0);
            cv = 16'hffff;
            put(1, 9'h1f8, 1);
            if (s == 0) foreach (wr[i]) send(wr[i]);
            repeat (4) begin
                lf = nx(lf);
                put(1, {1'b0, lf[7:0]}, 1);
                send(lf[7:0]);
            end
            crcs();
            put(1, 9'h04e, 0);
        end
        host_valid = 0;
        for (int i = 0; i < 7; i++) exp_res.push_back(i == 5 ? 9'h100 : 9'(
            i < 3 ? (i == 0 ? 8'h45 : i == 1 ? 8'h80 : 8'h00) : wr[i - 1]));
        wait (write_gate === 1'b1);
        #1 chk("select", {busy, dd, hs, dsh, dsl}, 8'h1d);
        drain();
        lf = nx(lf);
        d = lf[7:0];
        fm = '{8'h4d, 8'h02, 8'h00, 8'h01, 8'h01, d, 8'h07, 8'h00, lf[15:8],
               8'h00};
        // format command with one odd-numbered sector
        foreach (fm[i]) send(fm[i]);
        host_valid = 0;
        put(12, 9'h000, 0);
        cv = 16'hffff;
        put(1, 9'h1fe, 1);
        for (int i = 6; i < 10; i++) put(1, {1'b0, fm[i]}, 1);
        crcs();
        put(22, 9'h04e, 0);
        put(12, 9'h000, 0);
        cv = 16'hffff;
        put(1, 9'h1fb, 1);
        put(128, {1'b0, d}, 1);
        crcs();
        repeat (50) @(posedge clk);
        #1 chk("write_gate", {dreq, busy, write_gate}, 8'h02);
        pulse();
        wait (dreq === 1'b1);
        #1 chk("select", {write_gate, dd, hs, dsh, dsl}, 8'h1a);
        drain();
        for (int i = 0; i < 7; i++)
            exp_res.push_back(i == 0 ? 9'h002 : i < 3 ? 9'h000 : 9'h100);
        pulse();
        drain();
        @(posedge clk) #1 chk("busy", {busy, res_valid}, 8'h00);
        summarize();
    end
endmodule // tb_top
`default_nettype wire
